/* File: rtl/dplsc_defs.vh */
// constants for the lane-enable and aux-snoop control block
// included by the design files; definitions only
`ifndef DPLSC_DEFS_VH
`define DPLSC_DEFS_VH

`define DPLSC_OFS_SNOOP_STATUS 8'h12
`define DPLSC_OFS_LANE_CTRL 8'h13
`define DPLSC_SNOOP_STATUS_RESET 8'h00
`define DPLSC_LANE_CTRL_RESET 8'h00

`define DPLSC_PWR_MSB 6
`define DPLSC_PWR_LSB 5
`define DPLSC_LCNT_MSB 4
`define DPLSC_LCNT_LSB 0
`define DPLSC_SNOOP_DIS_BIT 7
`define DPLSC_ROUTE_MSB 5
`define DPLSC_ROUTE_LSB 4
`define DPLSC_LANE_OFF_MSB 3
`define DPLSC_LANE_OFF_LSB 0

`define DPLSC_ADDR_POWER_STATE 20'h00600
`define DPLSC_ADDR_LANE_COUNT 20'h00101
`define DPLSC_AUX_CMD_NATIVE_WR 4'h8
`define DPLSC_PWR_NORMAL 2'h1

`define DPLSC_ROUTE_AUTO 2'h0
`define DPLSC_ROUTE_N1_P2 2'h1
`define DPLSC_ROUTE_N2_P1 2'h2
`define DPLSC_ROUTE_OPEN 2'h3

`define DPLSC_SEL_DP4 2'h2
`define DPLSC_SEL_DP2_USB 2'h3

`endif

/* File: rtl/dplsc_aux_snoop.v */
// aux snoop decoder: flags native writes to the two link addresses, latches the data byte of every native write
// assumes the aux receiver presents one decoded request header and its
// first data byte, plus a one-cycle pulse when the write has completed
`timescale 1ns/1ps
`include "dplsc_defs.vh"

module dplsc_aux_snoop
(
  input wire sys_clk,
  input wire reset,
  input wire [3:0] aux_cmd,
  input wire [19:0] aux_addr,
  input wire [7:0] aux_data,
  input wire aux_wr_done,
  output reg pwr_hit,
  output reg lcnt_hit,
  output reg [7:0] hit_data
);

  wire native_wr;

  assign native_wr = aux_wr_done && (aux_cmd == `DPLSC_AUX_CMD_NATIVE_WR);

  ////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      pwr_hit <= 1'b0;
      lcnt_hit <= 1'b0;
      hit_data <= 8'h00;
    end
    else
    begin
      pwr_hit <= native_wr && (aux_addr == `DPLSC_ADDR_POWER_STATE);
      lcnt_hit <= native_wr && (aux_addr == `DPLSC_ADDR_LANE_COUNT);
      if (native_wr)
      begin
        hit_data <= aux_data;
      end
    end
  end

endmodule

/* File: rtl/dplsc_lane_ctrl.v */
// Function
// - power-state snoop held at bits 6:5
// - snoop on: power state gates lanes
// - lane-count snoop held at bits 4:0
// - snoop on: count picks lanes, rest off
// - dp-enable falling clears power state
// - dp-enable falling clears lane count
// - bit 7 disables snooping, resets zero
// - snoop off: per-lane disable bits rule
// - snoop on: disable bits stored, ignored
// - route override 00 follows select, flip
// - override 01: negative pin1, positive pin2
// - override 10: negative pin2, positive pin1
// - override 11: aux fully disconnected
// - both registers reset zero, reserved zero
// - select code; upper bit enables dp
//
// lane-enable and aux-to-sideband routing control, register offsets dp_link_snoop_status/dp_lane_and_aux_route_control
// assumes a byte register port from the serial slave: reg_addr, reg_wdata,
// reg_wr pulse, reg_rd pulse; read data appears one cycle after reg_rd
`timescale 1ns/1ps
`include "dplsc_defs.vh"

module dplsc_lane_ctrl
#(
  parameter LANES = 4
)
(
  input wire sys_clk,
  input wire reset,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  output reg reg_rvalid,
  input wire [1:0] crosspoint_select,
  input wire orientation_flip,
  input wire [3:0] aux_cmd,
  input wire [19:0] aux_addr,
  input wire [7:0] aux_data,
  input wire aux_wr_done,
  output reg [LANES-1:0] lane_enable,
  output reg aux_negative_to_sb1,
  output reg aux_negative_to_sb2,
  output reg aux_positive_to_sb1,
  output reg aux_positive_to_sb2
);

  ////////////////////////////////////////////////////////////////////////
  // lane mask for a snooped count; unknown counts leave all lanes off
  function [3:0] count_mask;
    input [4:0] cnt;
    begin
      case (cnt)
        5'h01: count_mask = 4'h1;
        5'h02: count_mask = 4'h3;
        5'h04: count_mask = 4'hF;
        default: count_mask = 4'h0;
      endcase
    end
  endfunction

  reg [1:0] power_state_r;
  reg [4:0] lane_count_r;
  reg snoop_off_r;
  reg [1:0] aux_route_override_r;
  reg lane0_off_r;
  reg lane1_off_r;
  reg lane2_off_r;
  reg lane3_off_r;
  reg dp_enable_select_bit_d_r;

  wire pwr_hit;
  wire lcnt_hit;
  wire [7:0] hit_data;
  wire dp_enable_select_bit;
  wire dp_enable_fall;
  wire [3:0] lane_off_vec;
  wire [7:0] status_val;
  wire [7:0] ctrl_val;

  reg [3:0] lane_enable_nxt;
  reg [3:0] route_nxt;

  // reset images kept whole so reserved bits stay tied to their zeros
  localparam [7:0] STATUS_RESET = `DPLSC_SNOOP_STATUS_RESET;
  localparam [7:0] CTRL_RESET = `DPLSC_LANE_CTRL_RESET;

  dplsc_aux_snoop u_snoop
  (
    .sys_clk(sys_clk),
    .reset(reset),
    .aux_cmd(aux_cmd),
    .aux_addr(aux_addr),
    .aux_data(aux_data),
    .aux_wr_done(aux_wr_done),
    .pwr_hit(pwr_hit),
    .lcnt_hit(lcnt_hit),
    .hit_data(hit_data)
  );

  // upper select bit is dp enable
  assign dp_enable_select_bit = crosspoint_select[1];
  assign dp_enable_fall = dp_enable_select_bit_d_r && !dp_enable_select_bit;
  assign lane_off_vec = {lane3_off_r, lane2_off_r, lane1_off_r, lane0_off_r};

  assign status_val = {1'b0, power_state_r, lane_count_r};
  assign ctrl_val = {snoop_off_r, 1'b0, aux_route_override_r, lane_off_vec};

  ////////////////////////////////////////////////////////////////////////
  // snooped status
  // captures land two edges after the aux write completes
  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      power_state_r <= STATUS_RESET[`DPLSC_PWR_MSB:`DPLSC_PWR_LSB];
      lane_count_r <= STATUS_RESET[`DPLSC_LCNT_MSB:`DPLSC_LCNT_LSB];
      // matches the idle select level, so no false fall follows reset
      dp_enable_select_bit_d_r <= 1'b0;
    end
    else
    begin
      dp_enable_select_bit_d_r <= dp_enable_select_bit;
      // the fall is a hardware clear, so it beats a same-cycle capture
      // clear on dp-enable fall
      if (dp_enable_fall)
      begin
        power_state_r <= 2'h0;
      end
      else if (pwr_hit && !snoop_off_r)
      begin
        power_state_r <= hit_data[1:0];
      end
      if (dp_enable_fall)
      begin
        lane_count_r <= 5'h00;
      end
      else if (lcnt_hit && !snoop_off_r)
      begin
        lane_count_r <= hit_data[4:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control register and read port
  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      snoop_off_r <= CTRL_RESET[`DPLSC_SNOOP_DIS_BIT];
      aux_route_override_r <= CTRL_RESET[`DPLSC_ROUTE_MSB:`DPLSC_ROUTE_LSB];
      lane0_off_r <= CTRL_RESET[`DPLSC_LANE_OFF_LSB];
      lane1_off_r <= CTRL_RESET[`DPLSC_LANE_OFF_LSB + 1];
      lane2_off_r <= CTRL_RESET[`DPLSC_LANE_OFF_LSB + 2];
      lane3_off_r <= CTRL_RESET[`DPLSC_LANE_OFF_MSB];
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      if (reg_wr && reg_addr == `DPLSC_OFS_LANE_CTRL)
      begin
        // reserved bit 6 is never stored, so it cannot read back set
        // snoop disable bit
        snoop_off_r <= reg_wdata[`DPLSC_SNOOP_DIS_BIT];
        aux_route_override_r <= reg_wdata[`DPLSC_ROUTE_MSB:`DPLSC_ROUTE_LSB];
        lane0_off_r <= reg_wdata[`DPLSC_LANE_OFF_LSB];
        lane1_off_r <= reg_wdata[`DPLSC_LANE_OFF_LSB + 1];
        lane2_off_r <= reg_wdata[`DPLSC_LANE_OFF_LSB + 2];
        lane3_off_r <= reg_wdata[`DPLSC_LANE_OFF_MSB];
      end
      reg_rvalid <= reg_rd;
      if (reg_rd)
      begin
        case (reg_addr)
          `DPLSC_OFS_SNOOP_STATUS: reg_rdata <= status_val;
          `DPLSC_OFS_LANE_CTRL: reg_rdata <= ctrl_val;
          // unmapped offsets read zero rather than aliasing a register
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // lane enables
  always @*
  begin
    lane_enable_nxt = 4'h0;
    if (snoop_off_r)
    begin
      lane_enable_nxt = ~lane_off_vec;
    end
    else if (power_state_r == `DPLSC_PWR_NORMAL)
    begin
      lane_enable_nxt = count_mask(lane_count_r);
    end
    // lanes never run while the crosspoint has dp turned off
    if (!dp_enable_select_bit)
    begin
      lane_enable_nxt = 4'h0;
    end
    else if (crosspoint_select == `DPLSC_SEL_DP2_USB)
    begin
      lane_enable_nxt = lane_enable_nxt & 4'h3;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // aux routing {n->sb1, n->sb2, p->sb1, p->sb2}
  always @*
  begin
    route_nxt = 4'h0;
    case (aux_route_override_r)
      `DPLSC_ROUTE_AUTO:
      begin
        if (dp_enable_select_bit)
        begin
          route_nxt = orientation_flip ? 4'h6 : 4'h9;
        end
      end
      // forced codes ignore select and flip, so codes 01 and 10 pass aux with dp off
      // forced n to pin1
      `DPLSC_ROUTE_N1_P2: route_nxt = 4'h9;
      `DPLSC_ROUTE_N2_P1: route_nxt = 4'h6;
      `DPLSC_ROUTE_OPEN: route_nxt = 4'h0;
      default: route_nxt = 4'h0;
    endcase
  end

  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      lane_enable <= {LANES{1'b0}};
      aux_negative_to_sb1 <= 1'b0;
      aux_negative_to_sb2 <= 1'b0;
      aux_positive_to_sb1 <= 1'b0;
      aux_positive_to_sb2 <= 1'b0;
    end
    else
    begin
      lane_enable <= lane_enable_nxt[LANES-1:0];
      aux_negative_to_sb1 <= route_nxt[3];
      aux_negative_to_sb2 <= route_nxt[2];
      aux_positive_to_sb1 <= route_nxt[1];
      aux_positive_to_sb2 <= route_nxt[0];
    end
  end

endmodule

/* File: sim/dplsc_monitor.sv */
// checker: read port, lane gating and aux routing relations
// sees the top-level ports only; bound at the foot of this file
`timescale 1ns/1ps
module dplsc_monitor #(parameter LANES = 4) (
  input wire sys_clk,
  input wire reset,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire reg_rvalid,
  input wire [1:0] crosspoint_select,
  input wire orientation_flip,
  input wire [LANES-1:0] lane_enable,
  input wire aux_negative_to_sb1,
  input wire aux_negative_to_sb2,
  input wire aux_positive_to_sb1,
  input wire aux_positive_to_sb2
);
  logic [7:0] ctrl_r;
  wire [3:0] sw = {aux_negative_to_sb1, aux_negative_to_sb2, aux_positive_to_sb1,
    aux_positive_to_sb2};
  // shadow of the control byte, same timing as the design register
  always @(posedge sys_clk)
    if (reset)
      ctrl_r <= 8'h00;
    else if (reg_wr && reg_addr == 8'h13)
      ctrl_r <= reg_wdata & 8'hBF;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  sequence s_rd13;
    reg_rd && reg_addr == 8'h13;
  endsequence
  ////////////////////////////////////////
  AST_RVALID: assert property (reg_rd |=> reg_rvalid)
    else $error("read valid missing");
  AST_RD_CTRL: assert property (s_rd13 |=> reg_rdata == $past(ctrl_r))
    else $error("control readback wrong");
  AST_RD_STAT: assert property (reg_rd && reg_addr == 8'h12 |=> !reg_rdata[7])
    else $error("status bit 7 set");
  AST_DP_OFF: assert property (!crosspoint_select[1] |=> lane_enable == '0)
    else $error("lanes on with dp off");
  AST_TWO_LANE: assert property (crosspoint_select == 2'h3 |=> !lane_enable[3:2])
    else $error("upper lanes on in two-lane select");
  AST_LANE_OFF: assert property (ctrl_r[7] && crosspoint_select == 2'h2
    |=> lane_enable == ~$past(ctrl_r[3:0])) else $error("lane off bits ignored");
  AST_RT00: assert property (ctrl_r[5:4] == 2'h0 |=> sw ==
    (!$past(crosspoint_select[1]) ? 4'h0 : $past(orientation_flip) ? 4'h6 : 4'h9))
    else $error("auto routing wrong");
  AST_RT01: assert property (ctrl_r[5:4] == 2'h1 |=> sw == 4'h9)
    else $error("route 01 wrong");
  AST_RT10: assert property (ctrl_r[5:4] == 2'h2 |=> sw == 4'h6)
    else $error("route 10 wrong");
  AST_RT11: assert property (ctrl_r[5:4] == 2'h3 |=> sw == 4'h0)
    else $error("route 11 not open");
endmodule

bind dplsc_lane_ctrl dplsc_monitor #(.LANES(LANES)) i_mon (.sys_clk(sys_clk), .reset(reset),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .crosspoint_select(crosspoint_select),
  .orientation_flip(orientation_flip), .lane_enable(lane_enable),
  .aux_negative_to_sb1(aux_negative_to_sb1), .aux_negative_to_sb2(aux_negative_to_sb2),
  .aux_positive_to_sb1(aux_positive_to_sb1), .aux_positive_to_sb2(aux_positive_to_sb2));

/* File: sim/dplsc_aux_src.sv */
// aux source model: one decoded request plus a done pulse per call
// called at a falling edge of sys_clk; lines scrambled between requests
`timescale 1ns/1ps
module dplsc_aux_src (
  input wire sys_clk,
  output logic [3:0] aux_cmd = 4'h0,
  output logic [19:0] aux_addr = 20'h00000,
  output logic [7:0] aux_data = 8'h00,
  output logic aux_wr_done = 1'b0
);
  task send(input logic [3:0] c, input logic [19:0] a, input logic [7:0] d, input int g);
    repeat (g) @(negedge sys_clk);
    aux_cmd = c;
    aux_addr = a;
    aux_data = d;
    aux_wr_done = 1'b1;
    @(negedge sys_clk);
    aux_wr_done = 1'b0;
    // stale values must not look like a held request
    aux_cmd = ~c;
    aux_addr = ~a;
    aux_data = ~d;
  endtask
endmodule

/* File: sim/dp_lane_enable_aux_snoop_ctrl_tb_top.sv */
// self-checking bench for the lane-enable and aux-snoop control block
// assumes the aux source model and the bound checker
`timescale 1ns/1ps
module dp_lane_enable_aux_snoop_ctrl_tb_top;
  logic sys_clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, orientation_flip = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, aux_data;
  logic [1:0] crosspoint_select = 2'h0;
  logic [3:0] aux_cmd, lane_enable;
  logic [19:0] aux_addr;
  logic reg_rvalid, aux_wr_done;
  wire aux_negative_to_sb1, aux_negative_to_sb2, aux_positive_to_sb1, aux_positive_to_sb2;
  wire [3:0] sw = {aux_negative_to_sb1, aux_negative_to_sb2, aux_positive_to_sb1,
    aux_positive_to_sb2};
  int n_fail = 0, cmp_count = 0, cyc = 0, seed = 32'hA381, ctrl = 0, pwr = 0, lcnt = 0, v;
  always #4 sys_clk = ~sys_clk;
  dplsc_lane_ctrl #(.LANES(4)) i_dut (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .crosspoint_select(crosspoint_select),
    .orientation_flip(orientation_flip), .aux_cmd(aux_cmd), .aux_addr(aux_addr),
    .aux_data(aux_data), .aux_wr_done(aux_wr_done), .lane_enable(lane_enable),
    .aux_negative_to_sb1(aux_negative_to_sb1), .aux_negative_to_sb2(aux_negative_to_sb2),
    .aux_positive_to_sb1(aux_positive_to_sb1), .aux_positive_to_sb2(aux_positive_to_sb2));
  dplsc_aux_src i_src (.sys_clk(sys_clk), .aux_cmd(aux_cmd), .aux_addr(aux_addr),
    .aux_data(aux_data), .aux_wr_done(aux_wr_done));
  ////////////////////////////////////////
  task cmp(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
      n_fail++;
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
    if (a == 8'h13)
      ctrl = d & 8'hBF;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    // rvalid stands one cycle only: look at it before the next edge
    cmp({7'h00, reg_rvalid}, 8'h01);
    cmp(reg_rdata, exp);
    @(negedge sys_clk);
  endtask
  task aux(input logic [3:0] c, input logic [19:0] a, input logic [7:0] d, input int g);
    i_src.send(c, a, d, g);
    if (c == 4'h8 && !ctrl[7] && a == 20'h00600)
      pwr = d[1:0];
    if (c == 4'h8 && !ctrl[7] && a == 20'h00101)
      lcnt = d[4:0];
  endtask
  function logic [7:0] lanes();
    logic [3:0] l;
    l = ctrl[7] ? ~ctrl[3:0] : pwr != 1 ? 4'h0 : lcnt == 1 ? 4'h1 : lcnt == 2 ? 4'h3 :
      lcnt == 4 ? 4'hF : 4'h0;
    if (!crosspoint_select[1])
      l = 4'h0;
    if (crosspoint_select == 2'h3)
      l[3:2] = 2'h0;
    return {4'h0, l};
  endfunction
  function logic [7:0] route();
    if (ctrl[5:4] == 2'h0)
      return !crosspoint_select[1] ? 8'h00 : orientation_flip ? 8'h06 : 8'h09;
    return ctrl[5:4] == 2'h1 ? 8'h09 : ctrl[5:4] == 2'h2 ? 8'h06 : 8'h00;
  endfunction
  task check_all;
    repeat (4) @(negedge sys_clk);
    cmp({4'h0, lane_enable}, lanes());
    cmp({4'h0, sw}, route());
    rd(8'h12, {1'b0, pwr[1:0], lcnt[4:0]});
    rd(8'h13, ctrl[7:0]);
  endtask
  task finish_test;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 10000)
    begin
      n_fail++;
      finish_test;
    end
  end
  initial
  begin
    repeat (2) @(negedge sys_clk);
    reset = 1'b0;
    rd(8'h55, 8'h00);
    check_all;
    repeat (300)
    begin
      v = $random(seed);
      case (v[2:0])
        3'h0, 3'h1: wr(v[8] ? 8'h13 : 8'h12, v[23:16]);
        3'h2:
        begin
          // dp-enable fall wipes both captures
          if (crosspoint_select[1] && !v[9])
            {pwr, lcnt} = 0;
          crosspoint_select = v[9:8];
          orientation_flip = v[10];
        end
        3'h3: aux(v[8] ? 4'h8 : v[15:12], 20'h00600, v[23:16], v[5:4]);
        default: aux(4'h8, v[8] ? 20'h00101 : v[27:8],
          {3'h0, v[9] ? v[20:16] : 5'h1 << v[11:10]}, v[5:4]);
      endcase
      check_all;
    end
    reset = 1'b1;
    @(negedge sys_clk);
    reset = 1'b0;
    {ctrl, pwr, lcnt} = 0;
    check_all;
    finish_test;
  end
endmodule
